/* File: ccp_defines.svh */
/*
  ccp_defines.svh: offsets, field positions, reset values and timing counts
  for the capture/compare/pwm channel.
  assumes: included by bare name from the channel module only; the package and the other modules do not include it.
*/
`ifndef CCP_DEFINES_SVH
`define CCP_DEFINES_SVH

// register offsets on the plain register port
`define CCP_OFS_CONTROL 4'h0
`define CCP_OFS_CAPSEL 4'h1
`define CCP_OFS_DATA_LOW 4'h2
`define CCP_OFS_DATA_HIGH 4'h3
`define CCP_OFS_STATUS 4'h4
`define CCP_OFS_OPTIONS 4'h5
`define CCP_OFS_PERIOD 4'h6
`define CCP_OFS_PWM_TIMER 4'h7

// control register fields
`define CCP_CTL_EN_BIT 7
`define CCP_CTL_OUT_BIT 5
`define CCP_CTL_FMT_BIT 4
`define CCP_CTL_RESET 8'h00

// status register fields
`define CCP_STS_FLAG_BIT 0
`define CCP_STS_IE_BIT 1

// options register fields
`define CCP_OPT_OD_BIT 0
`define CCP_OPT_TRIG_BIT 1
`define CCP_OPT_SLEEP_BIT 2
`define CCP_OPT_T1CLK_BIT 3

// pwm timer control fields (prescale select in bits 1:0, on in bit 7)
`define CCP_PT_ON_BIT 7
`define CCP_PT_PS_LSB 0

// instruction clock is the system clock divided by four
`define CCP_ICLK_DIV 4

`endif

/* File: ccp_pkg.sv */
/*
  ccp_pkg.sv: types shared by the capture/compare/pwm channel.
  assumes: ccp_defines.svh is on the include path.
*/
package ccp_pkg;
  // operating mode codes of the 4-bit mode field
  typedef enum logic [3:0] {
    CCP_MODE_OFF = 4'h0,
    CCP_MODE_TOG_CLR = 4'h1,
    CCP_MODE_TOG = 4'h2,
    CCP_MODE_CAP_ANY = 4'h3,
    CCP_MODE_CAP_FALL = 4'h4,
    CCP_MODE_CAP_RISE = 4'h5,
    CCP_MODE_CAP_R4 = 4'h6,
    CCP_MODE_CAP_R16 = 4'h7,
    CCP_MODE_SET = 4'h8,
    CCP_MODE_CLR = 4'h9,
    CCP_MODE_PULSE = 4'ha,
    CCP_MODE_PULSE_CLR = 4'hb,
    CCP_MODE_PWM0 = 4'hc,
    CCP_MODE_PWM1 = 4'hd,
    CCP_MODE_PWM2 = 4'he,
    CCP_MODE_PWM3 = 4'hf
  } ccp_mode_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccp_req_t;

  // channel pin signals (output enable high while driving)
  typedef struct packed {
    logic o;
    logic oe;
  } ccp_pin_t;
endpackage

/* File: ccp_sync.sv */
/*
  ccp_sync.sv: two flip-flop synchroniser for a level from another domain.
  assumes: one clock, asynchronous active-low reset.
*/
module ccp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // first stage, read only by the second stage
  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) $error("ccp_sync: WIDTH must be at least 1");
  end

  // two-stage capture of the asynchronous level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // ccp_sync

/* File: ccp_prescale.sv */
/*
  ccp_prescale.sv: instruction-clock phase and pwm prescaler counter.
  the low two bits of the pwm time base come from here.
  assumes: one clock; tick pulses one cycle each time the pwm timer steps.
*/
module ccp_prescale #(
  parameter int PS_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] ps_sel,
  output logic tick,
  output logic [1:0] fine
);
  // phase counter: 2 bits of system clock phase plus prescale bits
  logic [PS_W+1:0] cnt;
  logic [PS_W+1:0] lim;

  initial begin
    if (PS_W < 4) $error("ccp_prescale: PS_W must be at least 4");
  end

  // prescale 1, 4 or 16 instruction clocks per step (sel 3 acts as 16)
  always_comb begin
    unique case (ps_sel)
      2'h0: lim = (PS_W+2)'(3);
      2'h1: lim = (PS_W+2)'(15);
      default: lim = (PS_W+2)'(63);
    endcase
  end

  // the counter holds while the timer is stopped, so a wake resumes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (!run) begin
      cnt <= cnt;
    end else if (cnt >= lim) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + (PS_W+2)'(1);
    end
  end

  assign tick = run && (cnt >= lim);
  // fine bits: top two bits of the active counter span
  always_comb begin
    unique case (ps_sel)
      2'h0: fine = cnt[1:0];
      2'h1: fine = cnt[3:2];
      default: fine = cnt[5:4];
    endcase
  end
endmodule // ccp_prescale

/* File: ccp_channel.sv */
/*
  ccp_channel.sv: one capture/compare/pwm channel with its register port,
  its 8-bit pwm timer and a tap on an outside 16-bit timer.
  assumes: the 16-bit timer runs synchronous to ref_clk and takes a reset
  pulse from here; the channel pin and capture sources are asynchronous.
*/
// Implementation choices: the placing of the registers and the address-and-strobe port.
// Overview of operation
// - capture copies 16-bit timer into data pair
// - mode picks fall, rise, 4th, 16th, any
// - capture sets flag; only software clears
// - newer capture overwrites unread value
// - edge logic watches pin whatever its direction
// - three-bit field selects capture source
// - sleep holds timer; capture needs running clock
// - compare data pair against timer continuously
// - mode selects toggle, set, clear, pulse action
// - match sets flag and converter trigger
// - modes 1 and 11 reset the timer
// - zero control write clears output latch
// - vanished match cancels pending timer reset
// - enabled compare flag wakes the device only when timer16_sleep_clock is set
// - output modes may drive open drain
// - pwm up to ten bits, period and duty
// - period match clears timer, sets pin unless duty is zero, loads duty
// - pin clears at 10-bit time base match
// - alignment bit chooses left or right duty
`include "ccp_defines.svh"
module ccp_channel (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire ccp_pkg::ccp_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic [15:0] timer16_count_pair,
  input wire logic sleep_mode,
  input wire logic [7:0] capture_sources,
  input wire logic ccp_channel_pin_i,
  output ccp_pkg::ccp_pin_t ccp_channel_pin,
  output logic timer16_reset,
  output logic conv_trigger,
  output logic channel_irq_flag,
  output logic wake_request
);
  // software-visible registers
  logic [7:0] channel_control_reg;
  logic [2:0] capture_input_select_reg;
  logic [7:0] data_reg_low;
  logic [7:0] data_reg_high;
  logic channel_irq_enable;
  logic open_drain;
  logic trig_select;
  logic timer16_sleep_clock; // outside 16-bit timer keeps clocking in sleep
  logic [7:0] pwm_period_reg;
  logic [7:0] pwm_timer_control_reg;
  logic [7:0] pwm_timer_count;
  // channel state
  logic out_latch; // compare/pwm output latch
  logic [9:0] duty_buf; // pwm duty buffer
  logic [3:0] edge_cnt; // rising edge counter for prescaled capture
  logic prev_level; // delayed synchronised source for edge detect
  logic cmp_match_d; // match seen last cycle
  logic reset_pending; // timer reset due on the next edge
  logic pulse_on; // pulse-mode output active
  // decoded control
  ccp_pkg::ccp_mode_t mode;
  logic enabled;
  logic is_capture;
  logic is_compare;
  logic is_pwm;
  logic [7:0] src_raw;
  logic [7:0] src_sync;
  logic src_level;
  logic rise;
  logic fall;
  logic cap_event;
  logic cmp_match;
  logic cmp_hit;
  logic [9:0] duty_val;
  logic [9:0] time_base;
  logic pt_tick;
  logic [1:0] pt_fine;
  logic pt_run;
  logic period_hit;
  logic wr_ctl;
  logic pin_val; // output latch gated by the pwm duty match

  assign mode = ccp_pkg::ccp_mode_t'(channel_control_reg[3:0]);
  assign enabled = channel_control_reg[`CCP_CTL_EN_BIT];
  assign is_pwm = enabled && (channel_control_reg[3:2] == 2'h3);
  assign is_capture = enabled && (mode inside {ccp_pkg::CCP_MODE_CAP_ANY,
    ccp_pkg::CCP_MODE_CAP_FALL, ccp_pkg::CCP_MODE_CAP_RISE,
    ccp_pkg::CCP_MODE_CAP_R4, ccp_pkg::CCP_MODE_CAP_R16});
  assign is_compare = enabled && !is_pwm && !is_capture && (mode != ccp_pkg::CCP_MODE_OFF);
  assign wr_ctl = bus_req.wr && (bus_req.addr == `CCP_OFS_CONTROL);

  // pin level at source 0 is read back regardless of pin direction
  // pin feeds capture
  assign src_raw = {capture_sources[7:1], ccp_channel_pin_i};

  ccp_sync #(.WIDTH(8)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(src_raw),
    .sync_out(src_sync)
  );

  assign src_level = src_sync[capture_input_select_reg];
  assign rise = src_level && !prev_level;
  assign fall = !src_level && prev_level;

  // delayed level for edge detection; reads only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= src_level;
    end
  end

  // prescaled edge counter; restarts on any control write so a mode change
  // never finishes a count begun in another mode
  // restart edge counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt <= 4'h0;
    end else if (wr_ctl) begin
      edge_cnt <= 4'h0;
    end else if (is_capture && rise) begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end

  always_comb begin
    unique case (mode)
      ccp_pkg::CCP_MODE_CAP_ANY: cap_event = rise || fall;
      ccp_pkg::CCP_MODE_CAP_FALL: cap_event = fall;
      ccp_pkg::CCP_MODE_CAP_RISE: cap_event = rise;
      ccp_pkg::CCP_MODE_CAP_R4: cap_event = rise && (edge_cnt[1:0] == 2'h3);
      ccp_pkg::CCP_MODE_CAP_R16: cap_event = rise && (edge_cnt == 4'hf);
      default: cap_event = 1'b0;
    endcase
    cap_event = cap_event && is_capture && !wr_ctl;
  end

  assign cmp_match = (timer16_count_pair == {data_reg_high, data_reg_low});
  assign cmp_hit = is_compare && cmp_match && !cmp_match_d;

  // data pair: capture wins over a software write in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg_low <= 8'h00;
      data_reg_high <= 8'h00;
    end else if (cap_event) begin
      {data_reg_high, data_reg_low} <= timer16_count_pair;
    end else if (bus_req.wr && bus_req.addr == `CCP_OFS_DATA_LOW) begin
      data_reg_low <= bus_req.wdata;
    end else if (bus_req.wr && bus_req.addr == `CCP_OFS_DATA_HIGH) begin
      data_reg_high <= bus_req.wdata;
    end
  end

  // interrupt flag: set wins over a clear written in the same cycle
  // flag set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_irq_flag <= 1'b0;
    end else if (cap_event || cmp_hit || (is_pwm && period_hit)) begin
      channel_irq_flag <= 1'b1;
    end else if (bus_req.wr && bus_req.addr == `CCP_OFS_STATUS
        && !bus_req.wdata[`CCP_STS_FLAG_BIT]) begin
      channel_irq_flag <= 1'b0;
    end
  end

  // configuration registers written by software
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_control_reg <= `CCP_CTL_RESET;
      capture_input_select_reg <= 3'h0;
      channel_irq_enable <= 1'b0;
      open_drain <= 1'b0;
      trig_select <= 1'b0;
      timer16_sleep_clock <= 1'b0;
      pwm_period_reg <= 8'hff;
      pwm_timer_control_reg <= 8'h00;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        `CCP_OFS_CONTROL: channel_control_reg <= bus_req.wdata & 8'h9f;
        `CCP_OFS_CAPSEL: capture_input_select_reg <= bus_req.wdata[2:0];
        `CCP_OFS_STATUS: channel_irq_enable <= bus_req.wdata[`CCP_STS_IE_BIT];
        `CCP_OFS_OPTIONS: begin
          open_drain <= bus_req.wdata[`CCP_OPT_OD_BIT];
          trig_select <= bus_req.wdata[`CCP_OPT_TRIG_BIT];
          timer16_sleep_clock <= bus_req.wdata[`CCP_OPT_T1CLK_BIT];
        end
        `CCP_OFS_PERIOD: pwm_period_reg <= bus_req.wdata;
        `CCP_OFS_PWM_TIMER: pwm_timer_control_reg <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // compare bookkeeping: edge of match and deferred timer reset
  // deferred timer reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_match_d <= 1'b0;
      reset_pending <= 1'b0;
    end else begin
      cmp_match_d <= cmp_match && is_compare;
      reset_pending <= cmp_hit && (mode == ccp_pkg::CCP_MODE_TOG_CLR
        || mode == ccp_pkg::CCP_MODE_PULSE_CLR);
    end
  end
  // reset fires one edge after the trigger, only if the match still holds
  assign timer16_reset = reset_pending && cmp_match && is_compare;
  assign conv_trigger = cmp_hit && trig_select;

  // ten-bit duty, aligned by format bit
  // time base is the pwm timer plus two fine bits
  assign duty_val = channel_control_reg[`CCP_CTL_FMT_BIT]
    ? {data_reg_high, data_reg_low[7:6]} : {data_reg_high[1:0], data_reg_low};
  assign time_base = {pwm_timer_count, pt_fine};
  assign pt_run = pwm_timer_control_reg[`CCP_PT_ON_BIT] && !sleep_mode;
  assign period_hit = pt_tick && (pwm_timer_count == pwm_period_reg);

  ccp_prescale #(.PS_W(4)) u_ps (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(pt_run),
    .ps_sel(pwm_timer_control_reg[1:0]),
    .tick(pt_tick),
    .fine(pt_fine)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_timer_count <= 8'h00;
      duty_buf <= 10'h000;
    end else if (period_hit) begin
      pwm_timer_count <= 8'h00;
      duty_buf <= duty_val;
    end else if (pt_tick) begin
      pwm_timer_count <= pwm_timer_count + 8'h01;
    end
  end

  // output latch: zero control write clears it, compare actions, pwm
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_latch <= 1'b0;
      pulse_on <= 1'b0;
    end else if (wr_ctl && bus_req.wdata == 8'h00) begin
      out_latch <= 1'b0;
      pulse_on <= 1'b0;
    end else if (is_pwm) begin
      pulse_on <= 1'b0;
      if (period_hit) begin
        out_latch <= (duty_val != 10'h000);
      end else if (pt_run && time_base == duty_buf) begin
        out_latch <= 1'b0;
      end
    end else if (cmp_hit) begin
      unique case (mode)
        ccp_pkg::CCP_MODE_TOG_CLR, ccp_pkg::CCP_MODE_TOG: out_latch <= !out_latch;
        ccp_pkg::CCP_MODE_SET: out_latch <= 1'b1;
        ccp_pkg::CCP_MODE_CLR: out_latch <= 1'b0;
        default: begin
          out_latch <= 1'b1;
          pulse_on <= 1'b1;
        end
      endcase
    end else if (pulse_on) begin
      // pulse lasts one system clock
      out_latch <= 1'b0;
      pulse_on <= 1'b0;
    end
  end

  // duty match drops pin at once; the latch follows one edge later
  // so the high time is exactly duty steps of the time base
  assign pin_val = out_latch && !(is_pwm && time_base == duty_buf);

  always_comb begin
    ccp_channel_pin.o = pin_val;
    ccp_channel_pin.oe = (is_pwm || is_compare) && (!open_drain || !pin_val);
    if (open_drain) ccp_channel_pin.o = 1'b0;
  end

  // wake request from enabled flag; capture in sleep needs clock
  assign wake_request = sleep_mode && channel_irq_flag && channel_irq_enable
    && (timer16_sleep_clock || is_pwm);

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        `CCP_OFS_CONTROL: bus_rdata <= {channel_control_reg[7:6], out_latch,
          channel_control_reg[4:0]};
        `CCP_OFS_CAPSEL: bus_rdata <= {5'h00, capture_input_select_reg};
        `CCP_OFS_DATA_LOW: bus_rdata <= data_reg_low;
        `CCP_OFS_DATA_HIGH: bus_rdata <= data_reg_high;
        `CCP_OFS_STATUS: bus_rdata <= {6'h00, channel_irq_enable, channel_irq_flag};
        `CCP_OFS_OPTIONS: bus_rdata <= {4'h0, timer16_sleep_clock, 1'b0, trig_select,
          open_drain};
        `CCP_OFS_PERIOD: bus_rdata <= pwm_period_reg;
        `CCP_OFS_PWM_TIMER: bus_rdata <= pwm_timer_count;
        default: bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  // assertions
  sequence s_capture;
    cap_event;
  endsequence
  sequence s_hit_clr;
    cmp_hit && mode == ccp_pkg::CCP_MODE_TOG_CLR;
  endsequence

  chk_capture_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_capture |=> {data_reg_high, data_reg_low} == $past(timer16_count_pair))
    else $error("capture did not copy timer");
  chk_capture_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_capture |=> channel_irq_flag) else $error("capture flag not set");
  chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    channel_irq_flag && !(bus_req.wr && bus_req.addr == `CCP_OFS_STATUS)
    |=> channel_irq_flag) else $error("flag cleared without write");
  chk_rise_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cap_event && mode == ccp_pkg::CCP_MODE_CAP_RISE |-> rise)
    else $error("rise capture without rise");
  chk_timer_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_hit_clr ##1 (cmp_match && is_compare) |-> timer16_reset)
    else $error("timer reset missing");
  chk_reset_cancel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timer16_reset |-> cmp_match && $past(cmp_hit)) else $error("reset after match removed");
  chk_trigger: assert property (@(posedge ref_clk) disable iff (!rst_n)
    conv_trigger |-> cmp_hit ##1 channel_irq_flag) else $error("trigger without flag");
  chk_zero_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_ctl && bus_req.wdata == 8'h00 |=> !out_latch) else $error("latch not cleared");
  chk_pwm_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    period_hit |=> pwm_timer_count == 8'h00 && duty_buf == $past(duty_val))
    else $error("period reload wrong");
endmodule // ccp_channel

/* File: ccp_far_side.sv */
/*
  ccp_far_side.sv: model of the outside 16-bit timer and the channel pin.
  assumes: same clock as the channel; the bench steers run and the outside
  pin level, the channel clears the timer with a one-cycle pulse.
*/
module ccp_far_side (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic ext_level,
  input wire ccp_pkg::ccp_pin_t pin,
  input wire logic timer16_reset,
  output logic [15:0] timer16_count_pair,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] phase; // instruction clock phase

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // synchronous timer, cleared by the channel
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer16_count_pair <= 16'h0000;
    end else if (timer16_reset) begin
      timer16_count_pair <= 16'h0000;
    end else if (run && phase == 2'h3) begin
      // steps once per instruction clock, never on the raw clock
      timer16_count_pair <= timer16_count_pair + 16'h0001;
    end
  end

  // undriven pin follows the outside level (pull-up or source)
  assign pin_level = pin.oe ? pin.o : ext_level;
endmodule // ccp_far_side

/* File: tb.sv */
/*
  tb.sv: self-checking bench for the capture/compare/pwm channel.
  assumes: the channel and the far-side model share ref_clk at 20 MHz.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk;
  logic rst_n;
  ccp_pkg::ccp_req_t bus_req; // register port request
  logic [7:0] bus_rdata;
  logic [15:0] timer16_count_pair;
  logic pin_level; // pin as seen from outside
  ccp_pkg::ccp_pin_t pin; // channel pin drive
  logic timer16_reset;
  logic conv_trigger;
  logic channel_irq_flag;
  logic wake_request;
  logic run; // far timer running
  logic ext_level; // outside pin source
  logic sleep_mode;
  logic [7:0] capture_sources;
  int err_count;
  int cmp_count;

  ccp_channel ccp_channel_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .timer16_count_pair(timer16_count_pair),
    .sleep_mode(sleep_mode), .capture_sources(capture_sources),
    .ccp_channel_pin_i(pin_level), .ccp_channel_pin(pin), .timer16_reset(timer16_reset),
    .conv_trigger(conv_trigger), .channel_irq_flag(channel_irq_flag),
    .wake_request(wake_request));

  ccp_far_side ccp_far_side_inst (.ref_clk(ref_clk), .rst_n(rst_n), .run(run),
    .ext_level(ext_level), .pin(pin), .timer16_reset(timer16_reset),
    .timer16_count_pair(timer16_count_pair), .pin_level(pin_level));

  // free-running system clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic rd_cmp(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    cmp({8'h00, d}, {8'h00, exp});
  endtask

  task automatic flag_is(input logic exp);
    cmp({15'h0000, channel_irq_flag}, {15'h0000, exp});
  endtask

  // one pin level held long enough for sync and edge flops
  task automatic pin_to(input logic lvl);
    @(posedge ref_clk);
    ext_level <= lvl;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset();
    rd_cmp(4'h0, 8'h00);
    rd_cmp(4'h6, 8'hff);
    rd_cmp(4'h4, 8'h00);
    rd_cmp(4'h8, 8'h00);
  endtask

  // capture of a held timer, then an overwrite before any read
  task automatic t_capture();
    logic [7:0] lo;
    logic [7:0] hi;
    logic [15:0] exp;
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h0, 8'h85);
    wr_reg(4'h4, 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      run <= 1'b1;
      repeat (20 + 12 * k) @(posedge ref_clk);
      run <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      exp = timer16_count_pair;
      pin_to(1'b1);
      pin_to(1'b0);
      flag_is(1'b1);
      // pin held still across both byte reads
      if (k == 1) begin
        rd_reg(4'h2, lo);
        rd_reg(4'h3, hi);
        cmp({hi, lo}, exp);
      end
    end
    repeat (20) @(posedge ref_clk);
    flag_is(1'b1);
    wr_reg(4'h5, 8'h08);
    wr_reg(4'h4, 8'h03);
    #1;
    cmp({15'h0000, wake_request}, 16'h0000);
    @(posedge ref_clk);
    sleep_mode <= 1'b1;
    @(posedge ref_clk);
    #1;
    cmp({15'h0000, wake_request}, 16'h0001);
    @(posedge ref_clk);
    sleep_mode <= 1'b0;
    wr_reg(4'h4, 8'h00);
    #1;
    flag_is(1'b0);
  endtask

  // n-th pulse must flag; flag checked against fr after the rise and against ff after the fall
  task automatic t_edge(input logic [7:0] ctl, input int n, input logic fr, input logic ff);
    wr_reg(4'h0, ctl);
    wr_reg(4'h4, 8'h00);
    #1;
    repeat (n - 1) begin
      pin_to(1'b1);
      pin_to(1'b0);
    end
    flag_is(1'b0);
    pin_to(1'b1);
    flag_is(fr);
    pin_to(1'b0);
    flag_is(ff);
  endtask

  task automatic t_edges();
    t_edge(8'h84, 1, 1'b0, 1'b1);
    t_edge(8'h85, 1, 1'b1, 1'b1);
    t_edge(8'h83, 1, 1'b1, 1'b1);
    wr_reg(4'h0, 8'h86);
    pin_to(1'b1);
    pin_to(1'b0);
    pin_to(1'b1);
    pin_to(1'b0);
    t_edge(8'h86, 4, 1'b1, 1'b1);
    t_edge(8'h87, 16, 1'b1, 1'b1);
    wr_reg(4'h1, 8'h03);
    wr_reg(4'h0, 8'h85);
    wr_reg(4'h4, 8'h00);
    pin_to(1'b1);
    flag_is(1'b0);
    @(posedge ref_clk);
    capture_sources <= 8'h08;
    repeat (8) @(posedge ref_clk);
    #1;
    flag_is(1'b1);
    @(posedge ref_clk);
    capture_sources <= 8'h00;
    pin_to(1'b0);
  endtask

  // toggle-and-clear compare with converter trigger
  task automatic t_compare();
    logic [15:0] tgt;
    tgt = timer16_count_pair + 16'h0008;
    wr_reg(4'h2, tgt[7:0]);
    wr_reg(4'h3, tgt[15:8]);
    wr_reg(4'h5, 8'h02);
    wr_reg(4'h0, 8'h81);
    wr_reg(4'h4, 8'h00);
    run <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(posedge ref_clk);
      #1;
      if (conv_trigger === 1'b1) break;
    end
    cmp({15'h0000, conv_trigger}, 16'h0001);
    cmp(timer16_count_pair, tgt);
    @(posedge ref_clk);
    #1;
    cmp({15'h0000, timer16_reset}, 16'h0001);
    flag_is(1'b1);
    cmp({15'h0000, pin.o}, 16'h0001);
    @(posedge ref_clk);
    #1;
    cmp(timer16_count_pair, 16'h0000);
    run <= 1'b0;
    rd_cmp(4'h0, 8'ha1);
    wr_reg(4'h0, 8'h00);
    rd_cmp(4'h0, 8'h00);
  endtask

  // high time over two periods of 16 clocks (period 3, prescale 1)
  task automatic t_pwm(input logic [7:0] ctl, input logic [15:0] pair, input int exp);
    int h;
    h = 0;
    wr_reg(4'h6, 8'h03);
    wr_reg(4'h2, pair[7:0]);
    wr_reg(4'h3, pair[15:8]);
    wr_reg(4'h0, ctl);
    wr_reg(4'h7, 8'h80);
    repeat (40) @(posedge ref_clk);
    repeat (32) begin
      @(posedge ref_clk);
      #1;
      if (pin.o === 1'b1) h++;
    end
    cmp(16'(h), 16'(exp));
    cmp({15'h0000, pin.oe}, 16'h0001);
    wr_reg(4'h7, 8'h00);
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    run = 1'b0;
    ext_level = 1'b0;
    sleep_mode = 1'b0;
    capture_sources = 8'h00;
    err_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_capture();
    t_edges();
    t_compare();
    t_pwm(8'h8c, 16'h0008, 16);
    t_pwm(8'h9c, 16'h0100, 8);
    t_pwm(8'h8c, 16'h0000, 0);
    summarize();
  end

  // hang guard: a run this long counts as a mismatch
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    summarize();
  end
endmodule // tb
